// ==== rtl/afc_aux_control.sv ====
// Auxiliary front-end control: reference, clock source, excitation, switch, monitor
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module afc_aux_control #(
   parameter int EXC_START_CYC = afc_pkg::EXC_START_CYC_DEF
) (
   input wire logic MCLK_IN,
   input wire logic ARST_N_IN,
   input wire logic CE_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [afc_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   output logic [1:0] S_AXI_BRESP_OUT,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   input wire logic [afc_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   input wire logic CLK_PIN_IN,
   input wire logic CONV_DONE_IN,
   output logic EXT_CLK_SEL_OUT,
   output logic INT_OSC_ON_OUT,
   output afc_pkg::afc_ref_t REF_SEL_OUT,
   output afc_pkg::afc_ref_t MON_PAIR_OUT,
   output logic REF_READY_OUT,
   output logic [2:0] EXC_MAG_OUT,
   output logic EXC_ENABLE_OUT,
   output logic EXC_READY_OUT,
   output logic [2:0] EXC_ROUTE_FIRST_OUT,
   output logic [2:0] EXC_ROUTE_SECOND_OUT,
   output logic BURNOUT_OUT,
   output logic SWITCH_CLOSED_OUT,
   output logic [3:0] MUX_OUT,
   output logic PGA_BYPASS_OUT,
   output logic [2:0] GAIN_OUT,
   output logic MID_SHORT_OUT,
   output logic CONV_START_OUT,
   output logic CONVERTING_OUT
);
   import afc_pkg::*;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic aw_have;
   logic [ADDR_W-1:0] aw_addr;
   logic w_have;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic cmd_start;
   logic cmd_sleep;
   logic soft_rst;
   logic cfg_mux_wr;
   logic cfg_exc_wr;
   logic [31:0] rd_val;
   logic rd_ok;

   // Configuration state
   logic [3:0] mux_sel;
   logic [2:0] gain;
   logic bypass;
   logic cont_mode;
   afc_ref_t vref;
   afc_ref_t next_vref;
   logic burnout;
   logic sw_enable;
   logic [2:0] exc_mag;
   logic [2:0] route1;
   logic [2:0] route2;

   // Block state
   logic [2:0] clk_sync;
   logic clk_level;
   logic clk_rise;
   logic [1:0] edge_cnt;
   logic ext_clk;
   logic [REF_CNT_W-1:0] ref_cnt;
   logic ref_restart;
   logic asleep;
   logic exc_off;
   logic exc_on_now;
   logic [EXC_CNT_W-1:0] exc_cnt;
   logic exc_restart;
   logic sw_closed;
   logic mon_mode;
   afc_conv_t state;
   afc_conv_t next_state;

   // Write taken only once address and data are both held
   assign wr_fire = aw_have && w_have && !S_AXI_BVALID_OUT;
   assign cmd_start = wr_fire && aw_addr == ADDR_CMD && w_strb[0] && w_data[CMD_START_BIT];
   assign cmd_sleep = wr_fire && aw_addr == ADDR_CMD && w_strb[0] && w_data[CMD_SLEEP_BIT];
   assign soft_rst = wr_fire && aw_addr == ADDR_CMD && w_strb[0] && w_data[CMD_RESET_BIT];
   assign cfg_mux_wr = wr_fire && aw_addr == ADDR_CFG_MUX;
   assign cfg_exc_wr = wr_fire && aw_addr == ADDR_CFG_EXC;

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         aw_have <= 1'b0;
         aw_addr <= 4'h0;
         S_AXI_AWREADY_OUT <= 1'b1;
      end else if (CE_IN) begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_have <= 1'b1;
            aw_addr <= S_AXI_AWADDR_IN;
            S_AXI_AWREADY_OUT <= 1'b0;
         end else if (wr_fire) begin
            aw_have <= 1'b0;
         end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_AWREADY_OUT <= 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         w_have <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         S_AXI_WREADY_OUT <= 1'b1;
      end else if (CE_IN) begin
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_have <= 1'b1;
            w_data <= S_AXI_WDATA_IN;
            w_strb <= S_AXI_WSTRB_IN;
            S_AXI_WREADY_OUT <= 1'b0;
         end else if (wr_fire) begin
            w_have <= 1'b0;
         end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_WREADY_OUT <= 1'b1;
         end
      end
   end

   // Status is read-only, so a write to it is an error like an unmapped one
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= RESP_OKAY;
      end else if (CE_IN) begin
         if (wr_fire) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= (aw_addr == ADDR_CFG_MUX || aw_addr == ADDR_CFG_EXC ||
                                aw_addr == ADDR_CMD) ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      unique case (S_AXI_ARADDR_IN)
         ADDR_CFG_MUX: begin
            rd_val[BYPASS_BIT] = bypass;
            rd_val[GAIN_LSB +: 3] = gain;
            rd_val[MUX_LSB +: 4] = mux_sel;
            rd_val[CONT_BIT] = cont_mode;
         end
         ADDR_CFG_EXC: begin
            rd_val[VREF_LSB +: 2] = vref;
            rd_val[BURNOUT_BIT] = burnout;
            rd_val[SWEN_BIT] = sw_enable;
            rd_val[MAG_LSB +: 3] = exc_mag;
            rd_val[ROUTE1_LSB +: 3] = route1;
            rd_val[ROUTE2_LSB +: 3] = route2;
         end
         ADDR_CMD: begin
            rd_val = 32'h0;
         end
         ADDR_STATUS: begin
            rd_val[ST_EXTCLK_BIT] = ext_clk;
            rd_val[ST_REFRDY_BIT] = REF_READY_OUT;
            rd_val[ST_EXCRDY_BIT] = EXC_READY_OUT;
            rd_val[ST_SWITCH_BIT] = sw_closed;
            rd_val[ST_CONV_BIT] = state == AFC_CONV;
            rd_val[ST_SLEEP_BIT] = asleep;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         S_AXI_ARREADY_OUT <= 1'b1;
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= 32'h0;
         S_AXI_RRESP_OUT <= RESP_OKAY;
      end else if (CE_IN) begin
         if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= rd_val;
            S_AXI_RRESP_OUT <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_ARREADY_OUT <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------
   assign next_vref = afc_ref_t'(w_data[VREF_LSB +: 2]);

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         mux_sel <= 4'h0;
         gain <= GAIN_ONE;
         bypass <= 1'b0;
         cont_mode <= 1'b0;
         vref <= AFC_REF_INT;
         burnout <= 1'b0;
         sw_enable <= 1'b0;
         exc_mag <= MAG_OFF;
         route1 <= 3'h0;
         route2 <= 3'h0;
      end else if (CE_IN) begin
         if (soft_rst) begin
            mux_sel <= 4'h0;
            gain <= GAIN_ONE;
            bypass <= 1'b0;
            cont_mode <= 1'b0;
            vref <= AFC_REF_INT;
            burnout <= 1'b0;
            sw_enable <= 1'b0;
            exc_mag <= MAG_OFF;
            route1 <= 3'h0;
            route2 <= 3'h0;
         end else begin
            if (cfg_mux_wr && w_strb[0]) begin
               bypass <= w_data[BYPASS_BIT];
               gain <= w_data[GAIN_LSB +: 3];
               mux_sel <= w_data[MUX_LSB +: 4];
            end
            if (cfg_mux_wr && w_strb[1]) begin
               cont_mode <= w_data[CONT_BIT];
            end
            if (cfg_exc_wr && w_strb[0]) begin
               vref <= next_vref;
               burnout <= w_data[BURNOUT_BIT];
               sw_enable <= w_data[SWEN_BIT];
               exc_mag <= w_data[MAG_LSB +: 3];
            end
            // Routing takes effect as written; host orders magnitude first
            if (cfg_exc_wr && w_strb[1]) begin
               route1 <= w_data[ROUTE1_LSB +: 3];
               route2 <= w_data[ROUTE2_LSB +: 3];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock source detection
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         clk_sync <= 3'h0;
         clk_level <= 1'b0;
      end else if (CE_IN) begin
         clk_sync <= {clk_sync[1:0], CLK_PIN_IN};
         if (clk_sync[1] == clk_sync[2]) begin
            clk_level <= clk_sync[2];
         end
      end
   end

   // Slow external clocks only; each level must hold two MCLK samples, so one faster than a quarter of MCLK is missed
   assign clk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_level;

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         edge_cnt <= 2'h0;
         ext_clk <= 1'b0;
      end else if (CE_IN) begin
         // A reset command drops the external choice unless a qualifying edge lands in the same cycle
         if (clk_rise && edge_cnt == 2'(EXT_EDGES - 1)) begin
            ext_clk <= 1'b1;
         end else if (soft_rst) begin
            ext_clk <= 1'b0;
         end
         if (soft_rst) begin
            edge_cnt <= 2'h0;
         end else if (clk_rise && edge_cnt != 2'(EXT_EDGES - 1)) begin
            edge_cnt <= edge_cnt + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reference settling
   // ----------------------------------------------------------------
   assign ref_restart = soft_rst || (cmd_start && asleep) ||
                        (cfg_exc_wr && w_strb[0] && next_vref == AFC_REF_INT &&
                         vref != AFC_REF_INT);

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ref_cnt <= REF_CNT_W'(REF_SETTLE_CYC);
      end else if (CE_IN) begin
         if (ref_restart) begin
            ref_cnt <= REF_CNT_W'(REF_SETTLE_CYC);
         end else if (ref_cnt != '0) begin
            ref_cnt <= ref_cnt - 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power state, excitation and low-side switch
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         asleep <= 1'b0;
         exc_off <= 1'b0;
      end else if (CE_IN) begin
         if (cmd_sleep) begin
            asleep <= 1'b1;
            exc_off <= 1'b1;
         end else if (cmd_start || soft_rst) begin
            asleep <= 1'b0;
            exc_off <= 1'b0;
         end else if (cfg_exc_wr) begin
            exc_off <= 1'b0;
         end
      end
   end

   // Codes above the top current are treated as off
   assign exc_on_now = exc_mag != MAG_OFF && exc_mag <= MAG_MAX && !exc_off;
   assign exc_restart = exc_on_now && (!EXC_ENABLE_OUT || exc_mag != EXC_MAG_OUT);

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         exc_cnt <= EXC_CNT_W'(EXC_START_CYC);
      end else if (CE_IN) begin
         if (exc_restart) begin
            exc_cnt <= EXC_CNT_W'(EXC_START_CYC);
         end else if (exc_cnt != '0) begin
            exc_cnt <= exc_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sw_closed <= 1'b0;
      end else if (CE_IN) begin
         if (soft_rst || !sw_enable || cmd_sleep) begin
            sw_closed <= 1'b0;
         end else if (cmd_start) begin
            sw_closed <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         AFC_IDLE: begin
            if (cmd_start && !cmd_sleep) begin
               next_state = AFC_CONV;
            end
         end
         AFC_CONV: begin
            if (cmd_sleep) begin
               next_state = AFC_IDLE;
            end else if (CONV_DONE_IN && !cont_mode && !cmd_start) begin
               next_state = AFC_IDLE;
            end
         end
      endcase
      if (soft_rst) begin
         next_state = AFC_IDLE;
      end
   end

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state <= AFC_IDLE;
         CONVERTING_OUT <= 1'b0;
         CONV_START_OUT <= 1'b0;
      end else if (CE_IN) begin
         state <= next_state;
         CONVERTING_OUT <= next_state == AFC_CONV;
         CONV_START_OUT <= cmd_start && !cmd_sleep && !soft_rst;
      end
   end

   // ----------------------------------------------------------------
   // Analog control outputs
   // ----------------------------------------------------------------
   assign mon_mode = mux_sel == MUX_MON_REF || mux_sel == MUX_MON_SUPPLY;

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         EXT_CLK_SEL_OUT <= 1'b0;
         INT_OSC_ON_OUT <= 1'b1;
         REF_SEL_OUT <= AFC_REF_INT;
         MON_PAIR_OUT <= AFC_REF_INT;
         REF_READY_OUT <= 1'b0;
         EXC_MAG_OUT <= MAG_OFF;
         EXC_ENABLE_OUT <= 1'b0;
         EXC_READY_OUT <= 1'b0;
         EXC_ROUTE_FIRST_OUT <= 3'h0;
         EXC_ROUTE_SECOND_OUT <= 3'h0;
         BURNOUT_OUT <= 1'b0;
         SWITCH_CLOSED_OUT <= 1'b0;
         MUX_OUT <= 4'h0;
         PGA_BYPASS_OUT <= 1'b0;
         GAIN_OUT <= GAIN_ONE;
         MID_SHORT_OUT <= 1'b0;
      end else if (CE_IN) begin
         EXT_CLK_SEL_OUT <= ext_clk;
         INT_OSC_ON_OUT <= !ext_clk;
         REF_SEL_OUT <= mon_mode ? AFC_REF_INT : vref;
         MON_PAIR_OUT <= vref;
         REF_READY_OUT <= ref_cnt == '0 && !ref_restart;
         EXC_MAG_OUT <= exc_on_now ? exc_mag : MAG_OFF;
         EXC_ENABLE_OUT <= exc_on_now;
         EXC_READY_OUT <= exc_on_now && !exc_restart && exc_cnt == '0;
         EXC_ROUTE_FIRST_OUT <= route1;
         EXC_ROUTE_SECOND_OUT <= route2;
         BURNOUT_OUT <= burnout;
         SWITCH_CLOSED_OUT <= sw_closed && sw_enable;
         MUX_OUT <= mux_sel;
         PGA_BYPASS_OUT <= bypass || mon_mode;
         GAIN_OUT <= mon_mode ? GAIN_ONE : gain;
         MID_SHORT_OUT <= mux_sel == MUX_MID_SHORT;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!ARST_N_IN);

   mon_ref_a: assert property (CE_IN && mon_mode |=> REF_SEL_OUT == AFC_REF_INT)
      else $error("monitor mode not on internal reference");
   mon_gain_a: assert property (CE_IN && mon_mode |=> PGA_BYPASS_OUT && GAIN_OUT == GAIN_ONE)
      else $error("monitor mode did not force unity gain");
   ext_switch_a: assert property (CE_IN && clk_rise && edge_cnt == 2'h1 |=> ext_clk)
      else $error("second edge did not select external clock");
   ext_hold_a: assert property ($fell(ext_clk) |-> $past(soft_rst) && $past(CE_IN))
      else $error("external clock left without reset command");
   sw_open_a: assert property (CE_IN && !sw_enable |=> !SWITCH_CLOSED_OUT ##1 !sw_closed || sw_enable)
      else $error("switch not opened when enable cleared");
   sw_close_a: assert property (CE_IN && cmd_start && sw_enable && !cmd_sleep && !soft_rst
                                ##1 CE_IN |=> SWITCH_CLOSED_OUT)
      else $error("start did not close the switch");
   exc_sleep_a: assert property (CE_IN && cmd_sleep |=> !exc_on_now ##1 !EXC_ENABLE_OUT || !CE_IN)
      else $error("sleep did not power down excitation");
   exc_code_a: assert property (EXC_ENABLE_OUT |-> EXC_MAG_OUT != MAG_OFF && EXC_MAG_OUT <= MAG_MAX)
      else $error("excitation enabled with an off code");
   ref_wait_a: assert property (CE_IN && ref_restart |=> !REF_READY_OUT [*8])
      else $error("reference ready too early");
   conv_start_a: assert property ($rose(CONVERTING_OUT) |-> $past(cmd_start))
      else $error("conversion began without start command");

   ext_seen_c: cover property ($rose(EXT_CLK_SEL_OUT));
   sw_cycle_c: cover property ($rose(SWITCH_CLOSED_OUT) ##[1:50] $fell(SWITCH_CLOSED_OUT));
   conv_done_c: cover property ($rose(CONVERTING_OUT) ##[1:100] $fell(CONVERTING_OUT));
   mon_used_c: cover property (CE_IN && mux_sel == MUX_MON_SUPPLY);

endmodule

`default_nettype wire

// ==== rtl/afc_pkg.sv ====
// Constants and types for the auxiliary front-end control block
package afc_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int CLK_PERIOD_NS = 40;
   localparam int REF_SETTLE_US = 25;
   localparam int REF_SETTLE_CYC = (REF_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_CNT_W = 10;
   localparam int EXC_START_US = 200;
   localparam int EXC_START_CYC_DEF = (EXC_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXC_CNT_W = 13;
   localparam int EXT_EDGES = 2;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CFG_MUX = 4'h0;
   localparam logic [3:0] ADDR_CFG_EXC = 4'h4;
   localparam logic [3:0] ADDR_CMD = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Input configuration word
   localparam int BYPASS_BIT = 0;
   localparam int GAIN_LSB = 1;
   localparam int MUX_LSB = 4;
   localparam int CONT_BIT = 8;
   // Excitation and reference word
   localparam int VREF_LSB = 0;
   localparam int BURNOUT_BIT = 2;
   localparam int SWEN_BIT = 3;
   localparam int MAG_LSB = 4;
   localparam int ROUTE1_LSB = 8;
   localparam int ROUTE2_LSB = 12;
   // Command word
   localparam int CMD_START_BIT = 0;
   localparam int CMD_SLEEP_BIT = 1;
   localparam int CMD_RESET_BIT = 2;
   // Status word
   localparam int ST_EXTCLK_BIT = 0;
   localparam int ST_REFRDY_BIT = 1;
   localparam int ST_EXCRDY_BIT = 2;
   localparam int ST_SWITCH_BIT = 3;
   localparam int ST_CONV_BIT = 4;
   localparam int ST_SLEEP_BIT = 5;

   // ----------------------------------------------------------------
   // Codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      AFC_REF_INT = 2'h0,
      AFC_REF_EXT_FIRST = 2'h1,
      AFC_REF_EXT_SECOND = 2'h2,
      AFC_REF_SUPPLY = 2'h3
   } afc_ref_t;

   typedef enum logic {
      AFC_IDLE = 1'h0,
      AFC_CONV = 1'h1
   } afc_conv_t;

   localparam logic [3:0] MUX_MON_REF = 4'hc;
   localparam logic [3:0] MUX_MON_SUPPLY = 4'hd;
   localparam logic [3:0] MUX_MID_SHORT = 4'he;
   localparam logic [2:0] MAG_OFF = 3'h0;
   localparam logic [2:0] MAG_MAX = 3'h6;
   localparam logic [2:0] GAIN_ONE = 3'h0;

endpackage

// ==== tb/afc_aux_control_tb_top.sv ====
// Self-checking bench for the auxiliary front-end control block
`timescale 1ns/10ps
`default_nettype none
module afc_aux_control_tb_top;
   import afc_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and checks
   // ----------------------------------------------------------------
   logic clk = '0, rst_n = '0, aw = '0, w = '0, br = '0, ar = '0, rr = '0, xen = '0;
   logic [3:0] awa = '0, ara = '0, mx;
   logic [31:0] wd = '0, rdat, rd_d, m, seed = 32'hfab2;
   logic awr, wrd, bv, arr, rv, xs, ios, rrdy, ev, erdy, bo, sw, byp, ms, cs, cv, done, pin;
   logic [1:0] bresp, rresp, rsp;
   logic [2:0] em, r1, r2, gn;
   afc_ref_t rs, mp;
   int errors = 0;
   int comparisons = 0;
   always #20 clk = ~clk;
   afc_aux_control #(.EXC_START_CYC(20)) afc_aux_control_inst (
      .MCLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(1'h1), .S_AXI_AWVALID_IN(aw),
      .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(w),
      .S_AXI_WREADY_OUT(wrd), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf),
      .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_ARVALID_IN(ar), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
      .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .S_AXI_RDATA_OUT(rdat),
      .S_AXI_RRESP_OUT(rresp), .CLK_PIN_IN(pin), .CONV_DONE_IN(done), .EXT_CLK_SEL_OUT(xs),
      .INT_OSC_ON_OUT(ios), .REF_SEL_OUT(rs), .MON_PAIR_OUT(mp), .REF_READY_OUT(rrdy),
      .EXC_MAG_OUT(em), .EXC_ENABLE_OUT(ev), .EXC_READY_OUT(erdy), .EXC_ROUTE_FIRST_OUT(r1),
      .EXC_ROUTE_SECOND_OUT(r2), .BURNOUT_OUT(bo), .SWITCH_CLOSED_OUT(sw), .MUX_OUT(mx),
      .PGA_BYPASS_OUT(byp), .GAIN_OUT(gn), .MID_SHORT_OUT(ms), .CONV_START_OUT(cs),
      .CONVERTING_OUT(cv));
   afc_far_model afc_far_model_inst (.clk_in(clk), .start_in(cs), .ext_en_in(xen),
      .done_out(done), .pin_out(pin));
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      aw <= 1'h1;
      w <= 1'h1;
      br <= 1'h1;
      do begin
         @(posedge clk);
         if (awr) aw <= 1'h0;
         if (wrd) w <= 1'h0;
      end while (!bv);
      rsp = bresp;
      br <= 1'h0;
      @(posedge clk);
   endtask
   task rd(input logic [3:0] a);
      ara <= a;
      ar <= 1'h1;
      rr <= 1'h1;
      do begin
         @(posedge clk);
         if (arr) ar <= 1'h0;
      end while (!rv);
      rd_d = rdat;
      rsp = rresp;
      rr <= 1'h0;
      @(posedge clk);
   endtask
   task results;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      results;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      chk({ios, rrdy, sw}, 3'h4);
      rd(ADDR_CFG_EXC);
      chk(rd_d, 32'h0);
      for (int i = 0; i < 8; i++) begin
         seed = nx(seed);
         m = seed & 32'h7777;
         wr(ADDR_CFG_EXC, m);
         chk(rs, m[1:0]);
         chk(em, (m[6:4] == 3'h7) ? 3'h0 : m[6:4]);
         chk({r1, r2, bo}, {m[10:8], m[14:12], m[2]});
      end
      wr(ADDR_CFG_EXC, 32'h70);
      chk({em, ev}, 4'h0);
      wr(ADDR_CFG_EXC, 32'h3a);
      chk(erdy, 1'h0);
      repeat (25) @(posedge clk);
      chk(erdy, 1'h1);
      wr(ADDR_CMD, 32'h1);
      repeat (12) @(posedge clk);
      chk({sw, cv, ev}, 3'h5);
      wr(ADDR_CMD, 32'h2);
      repeat (2) @(posedge clk);
      chk({sw, ev}, 2'h0);
      wr(ADDR_CMD, 32'h1);
      wr(ADDR_CFG_EXC, 32'h32);
      repeat (2) @(posedge clk);
      chk(sw, 1'h0);
      for (int i = 12; i < 15; i++) begin
         wr(ADDR_CFG_MUX, 32'ha + (i << 4));
         m = 32'h0;
         m[12:0] = {i != 14, (i == 14) ? 3'h5 : 3'h0, (i == 14) ? 2'h2 : 2'h0, 2'h2, i == 14, i[3:0]};
         chk({byp, gn, rs, mp, ms, mx}, m);
      end
      repeat (3) wr(ADDR_CMD, 32'h1);
      xen <= 1'h1;
      repeat (30) @(posedge clk);
      chk({xs, ios}, 2'h2);
      xen <= 1'h0;
      repeat (4) @(posedge clk);
      wr(ADDR_CMD, 32'h4);
      repeat (2) @(posedge clk);
      chk({xs, rrdy}, 2'h0);
      repeat (640) @(posedge clk);
      chk(rrdy, 1'h1);
      rd(ADDR_STATUS);
      chk(rd_d, 32'h2);
      chk(rsp, RESP_OKAY);
      wr(ADDR_STATUS, 32'h1);
      chk(rsp, RESP_SLVERR);
      results;
   end
endmodule
`default_nettype wire

// ==== tb/afc_far_model.sv ====
// Far-side model: modulator done pulse and external clock source
`timescale 1ns/10ps
`default_nettype none
module afc_far_model (
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic ext_en_in,
   output logic done_out,
   output logic pin_out
);
   // ----------------------------------------------------------------
   // Behaviour
   // ----------------------------------------------------------------
   int cnt = 0;
   int ph = 0;
   initial {done_out, pin_out} = 2'h0;
   always @(posedge clk_in) begin
      done_out <= (cnt == 1);
      cnt <= start_in ? 5 : (cnt > 0 ? cnt - 1 : 0);
      ph <= ext_en_in ? ph + 1 : 0;
      // Grounded when idle, so no stray edges
      pin_out <= ext_en_in && (ph % 6 > 2);
   end
endmodule
`default_nettype wire
